// ==== src/cpf_crossbar_end.sv ====
/*
 Crossbar end: sends ingress packets, counts egress packets held per core
 but keeps only the latest packet for all cores, and grants them when the core drains.
 Assumes the device end limits outstanding egress packets to two.
*/
`timescale 1ns/10ps
`default_nettype none
module cpf_crossbar_end (
	input wire logic clk,
	input wire logic rst_n,
	cpf_link_if.crossbar link,
	input wire logic sendValid,
	output logic sendReady,
	input wire logic [cpf_pkg::INGRESS_WIDTH-1:0] sendData,
	input wire logic [cpf_pkg::CORE_COUNT-1:0] coreTake,
	output logic [cpf_pkg::CORE_COUNT-1:0] coreValid,
	output logic [cpf_pkg::EGRESS_WIDTH-1:0] coreData
);
	logic readyEarly_q;
	logic [cpf_pkg::INGRESS_WIDTH-1:0] sendStage_q;
	logic [cpf_pkg::INGRESS_WIDTH-1:0] bus_q;
	logic [1:0] held_q [cpf_pkg::CORE_COUNT];
	wire logic [cpf_pkg::CORE_COUNT-1:0] grants;
	logic [cpf_pkg::EGRESS_WIDTH-1:0] coreData_q;

	// Stop at stall; up to three already flagged still land
	assign sendReady = !link.ingressStall;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readyEarly_q <= 1'b0;
			sendStage_q <= '0;
			bus_q <= '0;
		end else begin
			readyEarly_q <= sendValid && sendReady;
			// Bus trails early ready by one cycle
			sendStage_q <= sendData;
			bus_q <= sendStage_q;
		end
	end
	assign link.ingressDataReadyEarly = readyEarly_q;
	assign link.ingressPacketBus = bus_q;

	for (genvar c = 0; c < cpf_pkg::CORE_COUNT; c++) begin : g_core
		logic take;
		logic granted_q;
		assign take = coreTake[c] && (held_q[c] != 2'h0);
		assign grants[c] = granted_q;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				held_q[c] <= 2'h0;
				granted_q <= 1'b0;
			end else begin
				granted_q <= take;
				if (link.egressRequest[c] && !take) begin
					held_q[c] <= held_q[c] + 2'h1;
				end else if (take && !link.egressRequest[c]) begin
					held_q[c] <= held_q[c] - 2'h1;
				end
			end
		end
		assign coreValid[c] = (held_q[c] != 2'h0);
	end
	assign link.egressGrant = grants;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coreData_q <= '0;
		end else if (link.egressRequest != '0) begin
			coreData_q <= link.egressPacketBus;
		end
	end
	assign coreData = coreData_q;
endmodule // cpf_crossbar_end
`default_nettype wire

// ==== src/cpf_device_end.sv ====
/*
 Device end: ingress request buffer with stall, egress per-core credit.
 Assumes the crossbar honours stall within three packets and grants
 each egress packet once.
*/
`timescale 1ns/10ps
`default_nettype none
module cpf_device_end (
	input wire logic clk,
	input wire logic rst_n,
	cpf_link_if.device link,
	output logic reqValid,
	input wire logic reqReady,
	output logic [cpf_pkg::INGRESS_WIDTH-1:0] reqData,
	input wire logic retValid,
	output logic retReady,
	input wire logic [cpf_pkg::EGRESS_WIDTH-1:0] retData,
	input wire logic [2:0] retCore
);
	localparam int CW = $clog2(cpf_pkg::BUF_DEPTH);
	localparam int OW = cpf_pkg::EGRESS_WIDTH + 3;
	localparam int STALL_ON = cpf_pkg::BUF_DEPTH - cpf_pkg::STALL_SKID - 1;
	localparam int STALL_OFF = cpf_pkg::BUF_DEPTH - cpf_pkg::RELEASE_ROOM;
	typedef enum logic [0:0] {
		STALL_OPEN = 1'b0,
		STALL_HELD = 1'b1
	} cpf_stall_t;

	// Ingress request buffer
	logic readyStage_q;
	logic [cpf_pkg::INGRESS_WIDTH-1:0] mem [cpf_pkg::BUF_DEPTH];
	logic [CW-1:0] wrPtr_q;
	logic [CW-1:0] rdPtr_q;
	logic [CW:0] used_q;
	logic bufFull;
	logic bufEmpty;
	logic push;
	logic pop;
	logic stallSet;
	logic stallClear;
	cpf_stall_t stallState_q;

	// Egress credit path
	logic fifoValid;
	logic fifoReady;
	logic [OW-1:0] fifoData;
	logic [2:0] headCore;
	logic [cpf_pkg::EGRESS_WIDTH-1:0] headPacket;
	logic [1:0] credit_q [cpf_pkg::CORE_COUNT];
	wire logic [cpf_pkg::CORE_COUNT-1:0] coreFull;
	logic [cpf_pkg::CORE_COUNT-1:0] headSelect;
	logic issue;
	logic [cpf_pkg::EGRESS_WIDTH-1:0] egressBus_q;
	logic [cpf_pkg::CORE_COUNT-1:0] egressReq_q;

	// Packet valid the cycle after early ready
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readyStage_q <= 1'b0;
		end else begin
			readyStage_q <= link.ingressDataReadyEarly;
		end
	end

	assign bufFull = (used_q == (CW+1)'(cpf_pkg::BUF_DEPTH));
	assign bufEmpty = (used_q == '0);

	// A packet arriving while the buffer is full is dropped so the pointers stay sane
	assign push = readyStage_q && !bufFull;
	assign pop = !bufEmpty && reqReady;
	assign reqValid = !bufEmpty;
	assign reqData = mem[rdPtr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= link.ingressPacketBus;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
		end else if (push) begin
			wrPtr_q <= wrPtr_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPtr_q <= '0;
		end else if (pop) begin
			rdPtr_q <= rdPtr_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			used_q <= '0;
		end else if (push && !pop) begin
			used_q <= used_q + 1'b1;
		end else if (pop && !push) begin
			used_q <= used_q - 1'b1;
		end
	end

	// Stall early enough to keep three slots for in-flight packets
	assign stallSet = (int'(used_q) >= STALL_ON);
	assign stallClear = (int'(used_q) <= STALL_OFF);

	// Gap between the thresholds keeps the stall from chattering
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stallState_q <= STALL_OPEN;
		end else begin
			case (stallState_q)
				STALL_OPEN: begin
					if (stallSet) begin
						stallState_q <= STALL_HELD;
					end
				end
				STALL_HELD: begin
					if (stallClear) begin
						stallState_q <= STALL_OPEN;
					end
				end
				default: begin
					stallState_q <= STALL_OPEN;
				end
			endcase
		end
	end
	assign link.ingressStall = (stallState_q == STALL_HELD);

	cpf_fifo #(
		.WIDTH(OW),
		.DEPTH(cpf_pkg::FIFO_DEPTH)
	) u_retFifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(retValid),
		.inReady(retReady),
		.inData({retCore, retData}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	assign headCore = fifoData[OW-1 -: 3];
	assign headPacket = fifoData[cpf_pkg::EGRESS_WIDTH-1:0];
	assign headSelect = 8'h01 << headCore;

	// Head-of-line blocking kept simple; order per core is preserved
	assign issue = fifoValid && !coreFull[headCore];
	assign fifoReady = issue;

	for (genvar c = 0; c < cpf_pkg::CORE_COUNT; c++) begin : g_credit
		logic inc;
		logic dec;
		assign coreFull[c] =
			(credit_q[c] >= 2'(cpf_pkg::MAX_OUTSTANDING));
		assign inc = issue && headSelect[c];
		// A grant with nothing owed is ignored
		assign dec = link.egressGrant[c] && (credit_q[c] != 2'h0);
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				credit_q[c] <= cpf_pkg::CREDIT_RESET;
			end else if (inc && !dec) begin
				credit_q[c] <= credit_q[c] + 2'h1;
			end else if (dec && !inc) begin
				credit_q[c] <= credit_q[c] - 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			egressBus_q <= '0;
		end else if (issue) begin
			egressBus_q <= headPacket;
		end
	end

	// Request is a one-cycle pulse beside the packet
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			egressReq_q <= '0;
		end else begin
			egressReq_q <= issue ? headSelect : '0;
		end
	end
	assign link.egressPacketBus = egressBus_q;
	assign link.egressRequest = egressReq_q;
endmodule // cpf_device_end
`default_nettype wire

// ==== src/cpf_fifo.sv ====
/*
 Small valid/ready FIFO, parameterised in width and depth.
 Assumes a power-of-two depth and one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // cpf_fifo
`default_nettype wire

// ==== src/cpf_link_if.sv ====
/*
 Link between the device end and the crossbar end.
 Assumes both ends share clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface cpf_link_if;
	logic ingressDataReadyEarly;
	logic [cpf_pkg::INGRESS_WIDTH-1:0] ingressPacketBus;
	logic ingressStall;
	logic [cpf_pkg::EGRESS_WIDTH-1:0] egressPacketBus;
	logic [cpf_pkg::CORE_COUNT-1:0] egressRequest;
	logic [cpf_pkg::CORE_COUNT-1:0] egressGrant;
	modport device (
		input ingressDataReadyEarly, ingressPacketBus, egressGrant,
		output ingressStall, egressPacketBus, egressRequest
	);
	modport crossbar (
		output ingressDataReadyEarly, ingressPacketBus, egressGrant,
		input ingressStall, egressPacketBus, egressRequest
	);
endinterface
`default_nettype wire

// ==== src/cpf_pkg.sv ====
/*
 Shared constants for the crossbar port flow control ends.
 Assumes both ends run on one clock with a synchronous low reset.
*/
// What this block does
// - Ingress carries 130-bit packets, ready and stall.
// - Device stalls crossbar when request buffer reaches 12 of 16.
// - Ready comes one cycle ahead of packet.
// - Stall releases only with room for six.
// - Three packets may follow stall; all accepted.
// - Egress drives 146-bit bus, two 8-bit groups.
// - Device counts ungranted packets per core.
// - At two outstanding, hold that core's next.
// - Crossbar counts two packets per core; keeps one packet for all cores.
package cpf_pkg;
	localparam int INGRESS_WIDTH = 130;
	localparam int EGRESS_WIDTH = 146;
	localparam int CORE_COUNT = 8;
	localparam int BUF_DEPTH = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int STALL_SKID = 3;
	localparam int RELEASE_ROOM = 6;
	localparam int MAX_OUTSTANDING = 2;
	localparam logic [1:0] CREDIT_RESET = 2'h0;
endpackage

// ==== verif/cpf_sva.sv ====
/*
 Link checker for both ends.
 Assumes it sits beside the link on the shared clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpf_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ingressDataReadyEarly,
	input wire logic [cpf_pkg::INGRESS_WIDTH-1:0] ingressPacketBus,
	input wire logic ingressStall,
	input wire logic [cpf_pkg::EGRESS_WIDTH-1:0] egressPacketBus,
	input wire logic [7:0] egressRequest,
	input wire logic [7:0] egressGrant
);
	logic [1:0] owed_q [8];
	logic [7:0] full, none, over;
	always_ff @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			if (!rst_n)
				owed_q[i] <= 2'h0;
			else
				owed_q[i] <= owed_q[i] + 2'(egressRequest[i]) - 2'(egressGrant[i]);
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			full[i] = owed_q[i] == 2'h2;
			none[i] = owed_q[i] == 2'h0;
			over[i] = owed_q[i] == 2'h3;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_reset_quiet: assert property ($rose(rst_n) |-> !ingressStall &&
		(egressRequest | egressGrant) == 8'h00) else $error("busy after reset");
	chk_stall_cause: assert property ($rose(ingressStall) |->
		$past(ingressDataReadyEarly) || $past(ingressDataReadyEarly, 2) ||
		$past(ingressDataReadyEarly, 3)) else $error("stall without traffic");
	chk_stall_hold: assert property ($rose(ingressStall) |=> ingressStall)
		else $error("stall released early");
	chk_skid_stop: assert property (ingressDataReadyEarly |->
		!$past(ingressStall)) else $error("packet sent under stall");
	chk_req_onehot: assert property ($onehot0(egressRequest))
		else $error("request to two cores");
	chk_credit_cap: assert property ((egressRequest & full) == 8'h00)
		else $error("third request to a core");
	chk_grant_owed: assert property ((egressGrant & none) == 8'h00)
		else $error("grant with nothing held");
	chk_count_bound: assert property (over == 8'h00)
		else $error("outstanding count out of range");
endmodule // cpf_sva
`default_nettype wire

// ==== verif/crossbar_port_flow_control_tb.sv ====
/*
 Bench joining both ends through the link.
 Assumes package, link, ends and checker compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module crossbar_port_flow_control_tb;
	localparam int W = cpf_pkg::EGRESS_WIDTH;
	localparam int V = cpf_pkg::INGRESS_WIDTH;
	localparam int ROOM = cpf_pkg::BUF_DEPTH - cpf_pkg::RELEASE_ROOM;
	typedef struct {
		logic [V-1:0] d;
		logic [W-1:0] e;
		logic [2:0] c;
		logic [7:0] v;
	} cpf_row_t;
	cpf_row_t rows [8];
	logic clk, rst_n, sendValid, reqReady, retValid;
	logic sendReady, reqValid, retReady;
	logic [V-1:0] sendData, reqData;
	logic [W-1:0] retData, coreData;
	logic [2:0] retCore;
	logic [7:0] coreTake, coreValid;
	logic took;
	int n_fail, n_checks, cyc, nReq0, sent, popped;
	cpf_link_if link();
	cpf_device_end i_cpf_device_end(.clk, .rst_n, .link(link.device),
		.reqValid, .reqReady, .reqData, .retValid, .retReady, .retData,
		.retCore);
	cpf_crossbar_end i_cpf_crossbar_end(.clk, .rst_n,
		.link(link.crossbar), .sendValid, .sendReady, .sendData,
		.coreTake, .coreValid, .coreData);
	cpf_sva i_cpf_sva(.clk, .rst_n,
		.ingressDataReadyEarly(link.ingressDataReadyEarly),
		.ingressPacketBus(link.ingressPacketBus),
		.ingressStall(link.ingressStall),
		.egressPacketBus(link.egressPacketBus),
		.egressRequest(link.egressRequest),
		.egressGrant(link.egressGrant));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		nReq0 += int'(link.egressRequest[0]);
		sent += int'(sendValid && sendReady);
		popped += int'(reqValid && reqReady);
		if (cyc == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(string what, logic [W-1:0] seen, logic [W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic send(logic [V-1:0] d);
		sendData = d;
		sendValid = 1'b1;
		while (sendReady !== 1'b1)
			tick(1);
		tick(1);
		sendValid = 1'b0;
	endtask
	// Leaves retValid high; the caller drops it
	task automatic ret(logic [W-1:0] d, logic [2:0] c);
		retData = d;
		retCore = c;
		retValid = 1'b1;
		while (retReady !== 1'b1)
			tick(1);
		tick(1);
	endtask
	task automatic pop(logic [V-1:0] d);
		for (int k = 0; k < 20 && reqValid !== 1'b1; k++)
			tick(1);
		chk("reqData", W'(reqData), W'(d));
		reqReady = 1'b1;
		tick(1);
	endtask
	initial begin
		{sendValid, reqReady, retValid, sendData, retData} = '0;
		{retCore, coreTake} = '0;
		rst_n = 1'b0;
		foreach (rows[i])
			rows[i] = '{V'(i * 3 + 1), ~W'(i), 3'(7 - i), 8'h80 >> i};
		tick(12);
		rst_n = 1'b1;
		chk("stall", W'(link.ingressStall), W'(0));
		foreach (rows[i]) begin
			send(rows[i].d);
			pop(rows[i].d);
			reqReady = 1'b0;
			ret(rows[i].e, rows[i].c);
			retValid = 1'b0;
			for (int k = 0; k < 9 && coreValid === 8'h00; k++)
				tick(1);
			tick(1);
			chk("coreValid", W'(coreValid), W'(rows[i].v));
			chk("coreData", coreData, rows[i].e);
			coreTake = coreValid;
			tick(1);
			coreTake = 8'h00;
		end
		tick(3);
		nReq0 = 0;
		for (int k = 0; k < 3; k++)
			ret(W'(k), 3'h0);
		retCore = 3'h1;
		retValid = 1'b1;
		tick(9);
		chk("issued", W'(nReq0), W'(2));
		chk("retReady", W'(retReady), W'(0));
		repeat (40) begin
			coreTake = coreValid;
			took = retValid && retReady;
			tick(1);
			if (took)
				retValid = 1'b0;
		end
		coreTake = 8'h00;
		chk("issued", W'(nReq0), W'(3));
		sent = 0;
		popped = 0;
		sendValid = 1'b1;
		repeat (24) begin
			sendData = V'(sent);
			tick(1);
		end
		sendValid = 1'b0;
		chk("stall", W'(link.ingressStall), W'(1));
		chk("sendReady", W'(sendReady), W'(0));
		chk("overfill", W'(sent > cpf_pkg::BUF_DEPTH), W'(0));
		for (int j = 0; j < sent; j++) begin
			chk("early", W'(!link.ingressStall && sent - popped > ROOM), 0);
			pop(V'(j));
		end
		reqReady = 1'b0;
		tick(2);
		chk("stall", W'(link.ingressStall), W'(0));
		complete_run();
	end
endmodule // crossbar_port_flow_control_tb
`default_nettype wire
